// [include/sync_pkg.sv]
/*
  Constants, state codes and field layout shared by the output
  synchronization block and its sample delay line.
  Assumes a single 200 MHz clock and synchronous pin inputs.
*/
// What this block does
// - Finish aligned to peers within one clock
// - Local reference restarts on data-start marker
// - Start internal copy at marker, then detect reference
// - Early/late detector steers copy onto reference
// - Act on comparison only inside window
// - Alignment moves delay pointer in data path
// - Pointer starts from delay preset value
// - Manual select uses manual delay field
// - Keep delay after reference is removed
// - Delay sits right before converter cores
// - Disable sync circuitry once process completes
// - Master select picks all-slaves or master/slave
// - Master outputs reference; slave aligns to it
// - Compensate only below plus/minus 64 clocks
package sync_pkg;

  // ********************************************************
  // Widths and sizes
  // ********************************************************
  localparam int SAMPLE_W = 16;
  localparam int PTR_W = 7;
  localparam int DELAY_DEPTH = 128;
  localparam int PHASE_W = 8;

  // ********************************************************
  // Timing counts: skew and window in cycles of the 5 ns clock, detection and lock in reference edges
  // ********************************************************
  localparam logic [7:0] MAX_SKEW = 8'h40;
  localparam logic [PHASE_W-1:0] WINDOW_HALF = 8'h08;
  localparam logic [2:0] DETECT_EDGES = 3'h4;
  localparam logic [2:0] LOCK_HITS = 3'h4;

  // ********************************************************
  // Reset values
  // ********************************************************
  localparam logic [PTR_W-1:0] PTR_RESET = 7'h00;
  localparam logic [PHASE_W-1:0] PHASE_RESET = 8'h00;

  // ********************************************************
  // Controller states
  // ********************************************************
  typedef enum logic [4:0] {
    S_IDLE   = 5'b00001,
    S_DETECT = 5'b00010,
    S_TRACK  = 5'b00100,
    S_DONE   = 5'b01000,
    S_FAIL   = 5'b10000
  } sync_state_e;

endpackage

// [hdl/sample_delay_line.sv]
/*
  Programmable sample delay line placed in front of the converter
  cores. Assumes tap is stable or changes one step at a time.
*/
`timescale 1ns/1ps
module sample_delay_line
  import sync_pkg::*;
#(
  parameter int WIDTH = 2*SAMPLE_W,
  parameter int DEPTH = DELAY_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] din,
  input wire logic [$clog2(DEPTH)-1:0] tap,
  output logic [WIDTH-1:0] dout
);

  if (DEPTH < 2) begin : g_chk
    $error("sample_delay_line needs DEPTH of two or more");
  end

  logic [WIDTH-1:0] stage_q [DEPTH];
  logic [WIDTH-1:0] dout_q;

  // ********************************************************
  // Shift chain and tap select
  // ********************************************************
  // Cleared at reset so the converters never see unknown codes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        stage_q[i] <= '0;
      end
      dout_q <= '0;
    end else begin
      stage_q[0] <= din;
      for (int i = 1; i < DEPTH; i++) begin
        stage_q[i] <= stage_q[i-1];
      end
      dout_q <= stage_q[tap];
    end
  end

  assign dout = dout_q;

endmodule

// [hdl/output_sync.sv]
/*
  Multi-device output synchronization: local reference from the
  data-start marker, detection of the external sync reference,
  early/late alignment of an internal copy by a delay pointer, and
  the delay itself just ahead of the converter cores.
  Assumes all inputs synchronous to CLK; control bits are plain pins.
*/
`timescale 1ns/1ps
module output_sync
  import sync_pkg::*;
#(
  parameter int PTR_BITS = PTR_W,
  parameter int PH_BITS = PHASE_W
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic DATA_START,
  input wire logic [SAMPLE_W-1:0] SAMPLE_I,
  input wire logic [SAMPLE_W-1:0] SAMPLE_Q,
  input wire logic SYNC_REFERENCE_IN,
  input wire logic SYNC_ENABLE,
  input wire logic SYNC_MASTER_SELECT,
  input wire logic SYNC_MANUAL_SELECT,
  input wire logic [PTR_W-1:0] SYNC_MANUAL_DELAY,
  input wire logic [PTR_W-1:0] SYNC_DELAY_PRESET,
  output logic [SAMPLE_W-1:0] CORE_A,
  output logic [SAMPLE_W-1:0] CORE_B,
  output logic SYNC_REFERENCE_OUT,
  output logic [PTR_W-1:0] SYNC_DELAY_POINTER,
  output logic SYNC_DETECTED,
  output logic SYNC_DONE,
  output logic SYNC_RANGE_ERROR
);

  if (PTR_BITS != PTR_W || PH_BITS != PHASE_W ||
      PH_BITS <= PTR_BITS) begin : g_chk
    $error("output_sync: phase must be wider than the pointer");
  end

  typedef struct packed {
    sync_state_e st;
    logic ena_prev;
    logic start_prev;
    logic ref_prev;
    logic local_run;
    logic [PHASE_W-1:0] local_cnt;
    logic [2:0] edge_cnt;
    logic [2:0] hit_cnt;
    logic [PTR_W-1:0] ptr;
    logic ref_out;
    logic detected;
    logic done;
    logic fail;
  } state_s;

  state_s s_q;
  state_s s_d;

  // Saturating three-bit increment for edge and hit counters
  function automatic logic [2:0] bump(input logic [2:0] v);
    bump = (v == 3'h7) ? v : 3'(v + 3'h1);
  endfunction

  // ********************************************************
  // Phase arithmetic
  // ********************************************************
  logic ref_rise;
  logic start_rise;
  logic [PHASE_W-1:0] copy_phase;
  logic copy_pulse;
  logic early;
  logic late;
  logic [PTR_W-1:0] ptr_step;
  logic signed [PTR_W+1:0] excursion;
  logic out_of_range;

  // The copy is the local reference seen through the data delay
  assign ref_rise = SYNC_REFERENCE_IN & ~s_q.ref_prev;
  assign start_rise = DATA_START & ~s_q.start_prev;
  assign copy_phase = PHASE_W'(s_q.local_cnt - {1'b0, s_q.ptr});
  assign copy_pulse = s_q.local_run && (copy_phase == '0);
  // Copy passed its zero before the reference edge: needs more delay
  assign early = (copy_phase != '0) && (copy_phase <= WINDOW_HALF);
  // Copy still to come: needs less delay
  assign late = copy_phase >= PHASE_W'(~WINDOW_HALF + 8'h01);
  assign ptr_step = early ? PTR_W'(s_q.ptr + 7'h01)
                          : PTR_W'(s_q.ptr - 7'h01);
  assign excursion = $signed({2'b00, ptr_step}) -
                     $signed({2'b00, SYNC_DELAY_PRESET});
  // A step that would take the delay 64 or more away from the preset, either way, is refused
  assign out_of_range = (excursion >= $signed({1'b0, MAX_SKEW})) ||
                        (excursion <= -$signed({1'b0, MAX_SKEW}));

  // ********************************************************
  // Next-state logic
  // ********************************************************
  always_comb begin
    s_d = s_q;
    s_d.ena_prev = SYNC_ENABLE;
    s_d.start_prev = DATA_START;
    s_d.ref_prev = SYNC_REFERENCE_IN;

    // Local reference free-runs once a data-start marker was seen
    if (start_rise) begin
      s_d.local_run = 1'b1;
      s_d.local_cnt = '0;
    end else if (s_q.local_run) begin
      s_d.local_cnt = PHASE_W'(s_q.local_cnt + 8'h01);
    end

    // Master drives its copy out as the reference for the slave
    s_d.ref_out = SYNC_ENABLE && SYNC_MASTER_SELECT && copy_pulse;

    if (!SYNC_ENABLE) begin
      s_d.st = S_IDLE;
      s_d.ptr = SYNC_DELAY_PRESET;
      s_d.edge_cnt = '0;
      s_d.hit_cnt = '0;
      s_d.detected = 1'b0;
      s_d.done = 1'b0;
      s_d.fail = 1'b0;
    end else if (SYNC_MANUAL_SELECT) begin
      // Manual delay overrides any search; the pointer follows SYNC_MANUAL_DELAY every cycle
      s_d.ptr = SYNC_MANUAL_DELAY;
      s_d.st = S_DONE;
      s_d.done = 1'b1;
    end else begin
      unique case (s_q.st)
        S_IDLE: begin
          s_d.st = SYNC_MASTER_SELECT ? S_DONE : S_DETECT;
          s_d.done = SYNC_MASTER_SELECT;
        end
        S_DETECT: begin
          // A few clean edges prove the reference is really present
          if (ref_rise) begin
            s_d.edge_cnt = bump(s_q.edge_cnt);
            // At or past the count, so edges seen before the marker
            // cannot leave the detector stuck
            if (s_q.edge_cnt >= DETECT_EDGES - 3'h1 && s_q.local_run) begin
              s_d.st = S_TRACK;
              s_d.detected = 1'b1;
            end
          end
        end
        S_TRACK: begin
          // Edges outside the window are ignored, not counted as misses
          if (ref_rise && copy_phase == '0) begin
            s_d.hit_cnt = bump(s_q.hit_cnt);
            if (s_q.hit_cnt == LOCK_HITS - 3'h1) begin
              s_d.st = S_DONE;
              s_d.done = 1'b1;
            end
          end else if (ref_rise && (early || late)) begin
            s_d.hit_cnt = '0;
            if (out_of_range) begin
              s_d.st = S_FAIL;
              s_d.fail = 1'b1;
            end else begin
              s_d.ptr = ptr_step;
            end
          end
        end
        S_DONE: begin
          // Detector is off: the reference may vanish, pointer holds
          s_d.st = S_DONE;
        end
        S_FAIL: begin
          s_d.st = S_FAIL;
        end
      endcase
      if (!SYNC_MASTER_SELECT && !s_q.ena_prev) begin
        s_d.st = S_DETECT;
      end
    end
  end

  // ********************************************************
  // State register
  // ********************************************************
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s_q.st <= S_IDLE;
      s_q.ena_prev <= 1'b0;
      s_q.start_prev <= 1'b0;
      s_q.ref_prev <= 1'b0;
      s_q.local_run <= 1'b0;
      s_q.local_cnt <= PHASE_RESET;
      s_q.edge_cnt <= 3'h0;
      s_q.hit_cnt <= 3'h0;
      s_q.ptr <= PTR_RESET;
      s_q.ref_out <= 1'b0;
      s_q.detected <= 1'b0;
      s_q.done <= 1'b0;
      s_q.fail <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ********************************************************
  // Data path delay, last stage before the cores
  // ********************************************************
  logic [2*SAMPLE_W-1:0] delayed;

  sample_delay_line #(
    .WIDTH(2*SAMPLE_W),
    .DEPTH(DELAY_DEPTH)
  ) u_delay (
    .clk(CLK),
    .rst(RST),
    .din({SAMPLE_I, SAMPLE_Q}),
    .tap(s_q.ptr),
    .dout(delayed)
  );

  assign CORE_A = delayed[2*SAMPLE_W-1:SAMPLE_W];
  assign CORE_B = delayed[SAMPLE_W-1:0];
  assign SYNC_REFERENCE_OUT = s_q.ref_out;
  assign SYNC_DELAY_POINTER = s_q.ptr;
  assign SYNC_DETECTED = s_q.detected;
  assign SYNC_DONE = s_q.done;
  assign SYNC_RANGE_ERROR = s_q.fail;

endmodule

// [testbench/output_sync_checker.sv]
/*
  Port-level timing checks for the output synchronization block.
  Assumes bind to output_sync and one clock domain on CLK.
*/
`timescale 1ns/1ps
module output_sync_checker
  import sync_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic SYNC_ENABLE,
  input wire logic SYNC_MASTER_SELECT,
  input wire logic SYNC_MANUAL_SELECT,
  input wire logic [PTR_W-1:0] SYNC_MANUAL_DELAY,
  input wire logic [PTR_W-1:0] SYNC_DELAY_PRESET,
  input wire logic SYNC_REFERENCE_OUT,
  input wire logic [PTR_W-1:0] SYNC_DELAY_POINTER,
  input wire logic SYNC_DETECTED,
  input wire logic SYNC_DONE,
  input wire logic SYNC_RANGE_ERROR
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  logic [1:0] age_q;
  logic auto_on;
  // Edges since reset; the first edges still show forced zeros
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) age_q <= 2'h0;
    else if (age_q != 2'h3) age_q <= age_q + 2'h1;
  end
  // Automatic slave alignment in progress
  assign auto_on = SYNC_ENABLE && !SYNC_MANUAL_SELECT && !SYNC_MASTER_SELECT;
  // ********************************************************
  // Assertions
  // ********************************************************
  a_idle_preset: assert property (age_q == 2'h3 && !SYNC_ENABLE |=>
    SYNC_DELAY_POINTER == $past(SYNC_DELAY_PRESET) && !SYNC_DONE)
    else $error("pointer not preset while idle");
  a_manual_force: assert property ($rose(SYNC_ENABLE) &&
    SYNC_MANUAL_SELECT |=> SYNC_DONE) else $error("manual done late");
  a_manual_hold: assert property (age_q == 2'h3 && SYNC_MANUAL_SELECT
    && $past(SYNC_MANUAL_SELECT) && SYNC_ENABLE && $past(SYNC_ENABLE) |->
    SYNC_DELAY_POINTER == $past(SYNC_MANUAL_DELAY))
    else $error("manual pointer moved");
  a_step_one: assert property (age_q == 2'h3 && auto_on |=>
    7'(SYNC_DELAY_POINTER - $past(SYNC_DELAY_POINTER))
    inside {7'h00, 7'h01, 7'h7f}) else $error("pointer jumped");
  a_done_hold: assert property (SYNC_DONE && SYNC_ENABLE |=>
    SYNC_DONE && $stable(SYNC_DELAY_POINTER))
    else $error("delay lost after done");
  a_err_keeps: assert property ($rose(SYNC_RANGE_ERROR) |->
    $stable(SYNC_DELAY_POINTER) && !SYNC_DONE)
    else $error("range error moved pointer");
  a_detect_first: assert property (auto_on && $rose(SYNC_DONE) |->
    SYNC_DETECTED) else $error("done without detection");
  a_master_done: assert property ($rose(SYNC_ENABLE) &&
    SYNC_MASTER_SELECT && !SYNC_MANUAL_SELECT |-> ##[1:3] SYNC_DONE)
    else $error("master not done");
  a_slave_quiet: assert property (age_q == 2'h3 &&
    !SYNC_MASTER_SELECT && !$past(SYNC_MASTER_SELECT) |->
    !SYNC_REFERENCE_OUT) else $error("slave drives reference");
  a_ref_pulse: assert property (SYNC_REFERENCE_OUT |=>
    !SYNC_REFERENCE_OUT [*8]) else $error("reference pulse too long");
  // Main scenarios reached
  c_auto_done: cover property (auto_on && $rose(SYNC_DONE));
  c_range: cover property ($rose(SYNC_RANGE_ERROR));
  c_ref_out: cover property (SYNC_REFERENCE_OUT);
endmodule

// [testbench/sync_source_model.sv]
/*
  Data source model: data-start marker and a periodic sync reference.
  Assumes the bench raises go together with the first sample.
*/
`timescale 1ns/1ps
module sync_source_model (
  input wire logic clk,
  input wire logic go,
  input wire logic ref_on,
  input wire logic [7:0] offset,
  output logic data_start = 1'b0,
  output logic sync_ref = 1'b0
);
  logic [7:0] cnt = 8'h00;
  // Marker held high from the first data on; skew is the device's job
  always @(posedge clk) begin
    data_start <= go;
    cnt <= go ? cnt + 8'h01 : 8'h00;
    // Four-cycle reference every 256 clocks; low when switched off
    sync_ref <= go && ref_on && 8'(cnt - offset) < 8'h04;
  end
endmodule

// [testbench/output_sync_test.sv]
/*
  Self-checking bench for output_sync with its data source model.
  Assumes sync_pkg compiled first; one 200 MHz clock.
*/
`timescale 1ns/1ps
module output_sync_test
  import sync_pkg::*;
;
  logic CLK = 0, RST = 1, DATA_START, SYNC_REFERENCE_IN, go = 0;
  logic ref_on = 0, stream = 0, SYNC_ENABLE = 0;
  logic SYNC_MASTER_SELECT = 0, SYNC_MANUAL_SELECT = 0;
  logic [7:0] off = 8'h00;
  logic [15:0] SAMPLE_I = 16'h0000, SAMPLE_Q = 16'h0000, CORE_A, CORE_B;
  logic [6:0] SYNC_MANUAL_DELAY = 7'h00, SYNC_DELAY_PRESET = 7'h00;
  logic [6:0] SYNC_DELAY_POINTER;
  logic SYNC_REFERENCE_OUT, SYNC_DETECTED, SYNC_DONE, SYNC_RANGE_ERROR;
  logic [16:0] rnd = 17'h103c7;
  logic [31:0] q[$];
  int err_count = 0, checks = 0, cyc = 0, n;
  output_sync i_dut (.CLK, .RST, .DATA_START, .SAMPLE_I, .SAMPLE_Q,
    .SYNC_REFERENCE_IN, .SYNC_ENABLE, .SYNC_MASTER_SELECT,
    .SYNC_MANUAL_SELECT, .SYNC_MANUAL_DELAY, .SYNC_DELAY_PRESET, .CORE_A,
    .CORE_B, .SYNC_REFERENCE_OUT, .SYNC_DELAY_POINTER, .SYNC_DETECTED,
    .SYNC_DONE, .SYNC_RANGE_ERROR);
  sync_source_model i_src (.clk(CLK), .go, .ref_on, .offset(off),
    .data_start(DATA_START), .sync_ref(SYNC_REFERENCE_IN));
  always #2.5 CLK = ~CLK;
  // ********************************************************
  // Compare and closing tasks
  // ********************************************************
  task report_and_stop();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [6:0] got, input logic [6:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: status %h want %h", $time, got, exp);
    end
  endtask
  task chk_smp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: core %h want %h", $time, got, exp);
    end
  endtask
  // True when the pointer sits within one clock of the target
  function logic [6:0] near(input logic [6:0] a, input logic [6:0] b);
    return 7'(7'(a - b) inside {7'h00, 7'h01, 7'h7f});
  endfunction
  // Next value of the 17-bit stimulus generator
  function automatic logic [16:0] lfsr(input logic [16:0] v);
    return {v[15:0], v[16] ^ v[13]};
  endfunction
  // Restart marker and alignment, then wait for done or error
  task run(input logic [6:0] p, input logic [7:0] o, input int lim);
    @(posedge CLK);
    SYNC_ENABLE <= 0;
    go <= 0;
    SYNC_DELAY_PRESET <= p;
    off <= o;
    ref_on <= 1;
    repeat (4) @(posedge CLK);
    go <= 1;
    repeat (4) @(posedge CLK);
    SYNC_ENABLE <= 1;
    @(negedge CLK);
    for (int i = 0; i < lim && SYNC_DONE !== 1'b1 &&
         SYNC_RANGE_ERROR !== 1'b1; i++) @(negedge CLK);
  endtask
  // ********************************************************
  // Stimulus, scoreboard and watchdog
  // ********************************************************
  // Random samples each edge; noted while the delay path is checked
  always @(posedge CLK) begin
    rnd <= lfsr(rnd);
    SAMPLE_I <= rnd[15:0];
    SAMPLE_Q <= rnd[16:1];
    if (stream) q.push_back({rnd[15:0], rnd[16:1]});
    if (++cyc == 60000) begin
      err_count++;
      $display("mismatch at %0t: timeout", $time);
      report_and_stop();
    end
  end
  // Sample reaches the cores pointer plus two edges later
  always @(negedge CLK)
    if (stream && q.size() >= int'(SYNC_DELAY_POINTER) + 3)
      chk_smp({CORE_A, CORE_B}, q.pop_front());
  initial begin
    repeat (6) @(posedge CLK);
    RST <= 0;
    run(7'h14, 8'h1b, 6000);
    chk(near(SYNC_DELAY_POINTER, 7'h1a) & 7'(SYNC_DONE), 7'h01);
    ref_on <= 0;
    repeat (1000) @(negedge CLK);
    chk(near(SYNC_DELAY_POINTER, 7'h1a) & 7'(SYNC_DONE), 7'h01);
    run(7'h28, 8'h23, 6000);
    chk(near(SYNC_DELAY_POINTER, 7'h22) & 7'(SYNC_DONE), 7'h01);
    run(7'h14, 8'h3c, 3000);
    chk({SYNC_DONE, SYNC_DETECTED, SYNC_DELAY_POINTER[4:0]}, 7'h34);
    run(7'h10, 8'h13, 0);
    for (int i = 0; i < 90 && SYNC_RANGE_ERROR !== 1'b1; i++) begin
      repeat (256) @(posedge CLK);
      off <= off + 8'h01;
    end
    // Look once the edge has settled, then drive on the next rising edge
    @(negedge CLK);
    chk(SYNC_DELAY_POINTER, 7'h4f);
    chk({SYNC_DONE, SYNC_RANGE_ERROR}, 7'h01);
    @(posedge CLK);
    // Master/slave pairing assumes this device and exactly one peer
    SYNC_MASTER_SELECT <= 1;
    run(7'h05, 8'h40, 10);
    chk(7'(SYNC_DONE), 7'h01);
    for (int i = 0; i < 300 && SYNC_REFERENCE_OUT !== 1'b1; i++)
      @(negedge CLK);
    n = 0;
    do begin
      @(negedge CLK);
      n++;
    end while (n < 300 && SYNC_REFERENCE_OUT !== 1'b1);
    chk(7'(n == 256), 7'h01);
    @(posedge CLK);
    SYNC_MASTER_SELECT <= 0;
    SYNC_MANUAL_SELECT <= 1;
    // Mode and manual delay change only while the block is disabled
    for (int k = 0; k < 3; k++) begin
      SYNC_ENABLE <= 0;
      SYNC_MANUAL_DELAY <= k == 0 ? 7'h00 : k == 1 ? 7'h05 : 7'h7f;
      run(7'h30, 8'h40, 4);
      chk(SYNC_DELAY_POINTER, SYNC_MANUAL_DELAY);
      stream <= 1;
      repeat (400) @(posedge CLK);
      stream <= 0;
      repeat (2) @(posedge CLK);
      q.delete();
    end
    report_and_stop();
  end
endmodule
bind output_sync output_sync_checker i_chk (.CLK, .RST, .SYNC_ENABLE,
  .SYNC_MASTER_SELECT, .SYNC_MANUAL_SELECT, .SYNC_MANUAL_DELAY,
  .SYNC_DELAY_PRESET, .SYNC_REFERENCE_OUT, .SYNC_DELAY_POINTER,
  .SYNC_DETECTED, .SYNC_DONE, .SYNC_RANGE_ERROR);
